// [hdl/mmbd_map.svh]
// register offsets, field positions, reset values and vectors of the memory map
`ifndef MMBD_MAP_SVH
`define MMBD_MAP_SVH

`define MMBD_OFS_INDIRECT_PORT   7'h00
`define MMBD_OFS_PC_LOW          7'h02
`define MMBD_OFS_CORE_STATUS     7'h03
`define MMBD_OFS_INDIRECT_PTR    7'h04
`define MMBD_OFS_PC_HIGH_LATCH   7'h0a
`define MMBD_OFS_INT_CONTROL     7'h0b
`define MMBD_OFS_GPR_FIRST       7'h20
`define MMBD_OFS_ODD_SHARED      7'h40
`define MMBD_OFS_BANK_LAST       7'h7f

`define MMBD_ST_BANK_PTR_HI      7
`define MMBD_ST_BANK_HI          6
`define MMBD_ST_BANK_LO          5
`define MMBD_ST_RO_HI            4
`define MMBD_ST_RO_LO            3

`define MMBD_RST_STATUS          8'h18
`define MMBD_RST_PTR             8'h00
`define MMBD_RST_PC_HIGH_LATCH   8'h00
`define MMBD_RST_INT_CONTROL     8'h00
`define MMBD_RESET_VECTOR        13'h0000
`define MMBD_INT_VECTOR          13'h0004
`define MMBD_PROG_LAST           13'h07ff
`define MMBD_ODD_RAM_BASE        7'h60

`endif

// [hdl/mmbd_pkg.sv]
// types shared by the memory map and bank decode block
`default_nettype none
package mmbd_pkg;

  // data access request from the core
  typedef struct packed {
    logic       req;
    logic       we;
    logic       indirect;
    logic [6:0] offset;
    logic [7:0] wdata;
  } mmbd_dreq_t;

  // access passed on to the peripheral register space
  typedef struct packed {
    logic       sel;
    logic       we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } mmbd_periph_t;

  // decoded target of a data access
  typedef enum logic [7:0] {
    MMBD_R_NONE   = 8'h01,
    MMBD_R_PCL    = 8'h02,
    MMBD_R_STATUS = 8'h04,
    MMBD_R_PTR    = 8'h08,
    MMBD_R_PROGRAM_COUNTER_HIGH_LATCH = 8'h10,
    MMBD_R_INTERRUPT_CONTROL = 8'h20,
    MMBD_R_RAM    = 8'h40,
    MMBD_R_PERIPH = 8'h80
  } mmbd_region_t;

endpackage : mmbd_pkg
`default_nettype wire

// [hdl/mmbd_top.sv]
// program counter, program memory addressing and banked data memory decode
`include "mmbd_map.svh"
`default_nettype none

// What this block does
// - thirteen-bit program counter spanning an 8K by 14-bit word space
// - only addresses up to 07ffh exist; higher addresses wrap via low bits
// - counter loads 0000h at reset and 0004h when an interrupt is taken
// - program and data sides use separate ports, usable in the same cycle
// - user code may read program words through a separate read path
// - status bits 6 and 5 select data bank 0 to 3
// - each bank holds 128 byte offsets, combined with the bank number
// - low offsets decode to special registers, higher ones to general RAM
// - core registers are mirrored; status is reachable in all four banks
// - data is reached by direct offset or via the indirect pointer
// - unimplemented data locations read as zero
module mmbd_top #(
  parameter int PROG_AW = 11,
  parameter int RAM_DEPTH = 128
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  // program counter control from the core
  input  wire logic                 pc_inc,
  input  wire logic                 pc_jump,
  input  wire logic [10:0]          pc_jump_target,
  input  wire logic                 int_take,
  // program memory port
  output logic [PROG_AW-1:0]        pmem_addr_ff,
  input  wire logic [13:0]          pmem_rdata,
  output logic [12:0]               pc_ff,
  // user program read path
  input  wire logic                 prog_rd_req,
  input  wire logic [12:0]          prog_rd_addr,
  output logic [13:0]               prog_rd_data_ff,
  output logic                      prog_rd_valid_ff,
  // data access from the core
  input  wire mmbd_pkg::mmbd_dreq_t dreq,
  input  wire logic                 alu_flags_we,
  input  wire logic [2:0]           alu_flags,
  output logic [7:0]                drdata_ff,
  output logic                      drvalid_ff,
  // core register contents
  output logic [7:0]                core_status_ff,
  output logic [7:0]                indirect_pointer_ff,
  output logic [7:0]                pc_high_latch_ff,
  output logic [7:0]                interrupt_control_ff,
  // peripheral register space
  output mmbd_pkg::mmbd_periph_t    periph_ff,
  input  wire logic                 periph_hit,
  input  wire logic [7:0]           periph_rdata
);

  logic [12:0]          nxt_pc;
  logic [PROG_AW-1:0]   nxt_pmem_addr;
  logic                 pend_user_ff;
  logic                 nxt_pend_user;
  logic [13:0]          nxt_prog_rd_data;
  logic                 nxt_prog_rd_valid;

  logic [8:0]           eff_addr;
  logic [1:0]           bank;
  logic [6:0]           ofs;
  logic                 via_port;
  mmbd_pkg::mmbd_region_t region;
  logic [6:0]           ram_idx;
  logic [7:0]           local_rd;
  logic                 wr;

  logic [7:0]           nxt_status;
  logic [7:0]           nxt_ptr;
  logic [7:0]           nxt_program_counter_high_latch;
  logic [7:0]           nxt_interrupt_control;
  mmbd_pkg::mmbd_periph_t nxt_periph;
  logic [7:0]           local_rd_ff;
  logic                 from_periph_ff;
  logic                 pend_read_ff;
  logic [7:0]           nxt_drdata;
  logic                 nxt_drvalid;

  logic [7:0]           ram [RAM_DEPTH];

  // data address: direct uses the bank bits, indirect the pointer and its page bit
  always_comb begin
    via_port = (dreq.offset == `MMBD_OFS_INDIRECT_PORT) || dreq.indirect;
    if (via_port) begin
      eff_addr = {core_status_ff[`MMBD_ST_BANK_PTR_HI], indirect_pointer_ff};
    end else begin
      eff_addr = {core_status_ff[`MMBD_ST_BANK_HI],
                  core_status_ff[`MMBD_ST_BANK_LO], dreq.offset};
    end
    bank = eff_addr[8:7];
    ofs  = eff_addr[6:0];
  end

  // region decode; core registers ignore the bank bits entirely
  always_comb begin
    ram_idx = 7'h00;
    case (ofs)
      `MMBD_OFS_INDIRECT_PORT: region = mmbd_pkg::MMBD_R_NONE;
      `MMBD_OFS_PC_LOW:        region = mmbd_pkg::MMBD_R_PCL;
      `MMBD_OFS_CORE_STATUS:   region = mmbd_pkg::MMBD_R_STATUS;
      `MMBD_OFS_INDIRECT_PTR:  region = mmbd_pkg::MMBD_R_PTR;
      `MMBD_OFS_PC_HIGH_LATCH: region = mmbd_pkg::MMBD_R_PROGRAM_COUNTER_HIGH_LATCH;
      `MMBD_OFS_INT_CONTROL:   region = mmbd_pkg::MMBD_R_INTERRUPT_CONTROL;
      default: begin
        if (ofs < `MMBD_OFS_GPR_FIRST) begin
          region = mmbd_pkg::MMBD_R_PERIPH;
        end else begin
          region = mmbd_pkg::MMBD_R_RAM;
          // banks 2/3 drop bit 8, so they land on banks 0/1
          if (bank[0] && (ofs < `MMBD_OFS_ODD_SHARED)) begin
            ram_idx = ofs - `MMBD_OFS_GPR_FIRST + `MMBD_ODD_RAM_BASE;
          end else begin
            ram_idx = ofs - `MMBD_OFS_GPR_FIRST;
          end
        end
      end
    endcase
  end

  // local read value; the indirect port read through itself gives zero
  always_comb begin
    case (region)
      mmbd_pkg::MMBD_R_PCL:    local_rd = pc_ff[7:0];
      mmbd_pkg::MMBD_R_STATUS: local_rd = core_status_ff;
      mmbd_pkg::MMBD_R_PTR:    local_rd = indirect_pointer_ff;
      mmbd_pkg::MMBD_R_PROGRAM_COUNTER_HIGH_LATCH: local_rd = pc_high_latch_ff;
      mmbd_pkg::MMBD_R_INTERRUPT_CONTROL: local_rd = interrupt_control_ff;
      mmbd_pkg::MMBD_R_RAM:    local_rd = ram[ram_idx];
      default:                 local_rd = 8'h00;
    endcase
    wr = dreq.req && dreq.we;
  end

  // core register next values
  always_comb begin
    nxt_status = core_status_ff;
    nxt_ptr    = indirect_pointer_ff;
    nxt_program_counter_high_latch = pc_high_latch_ff;
    nxt_interrupt_control = interrupt_control_ff;
    if (alu_flags_we) begin
      nxt_status[2:0] = alu_flags;
    end
    if (wr) begin
      case (region)
        mmbd_pkg::MMBD_R_STATUS: begin
          // timeout and power-down flags are not writable by software
          nxt_status = {dreq.wdata[7:5], core_status_ff[`MMBD_ST_RO_HI:`MMBD_ST_RO_LO],
                        dreq.wdata[2:0]};
        end
        mmbd_pkg::MMBD_R_PTR:    nxt_ptr    = dreq.wdata;
        mmbd_pkg::MMBD_R_PROGRAM_COUNTER_HIGH_LATCH: nxt_program_counter_high_latch = {3'h0, dreq.wdata[4:0]};
        mmbd_pkg::MMBD_R_INTERRUPT_CONTROL: nxt_interrupt_control = dreq.wdata;
        default:                 nxt_status = nxt_status;
      endcase
    end
  end

  // program counter; interrupt beats a computed jump beats a step
  always_comb begin
    nxt_pc = pc_ff;
    if (int_take) begin
      nxt_pc = `MMBD_INT_VECTOR;
    end else if (wr && (region == mmbd_pkg::MMBD_R_PCL)) begin
      nxt_pc = {pc_high_latch_ff[4:0], dreq.wdata};
    end else if (pc_jump) begin
      nxt_pc = {pc_high_latch_ff[4:3], pc_jump_target};
    end else if (pc_inc) begin
      nxt_pc = 13'(pc_ff + 13'h0001);
    end
  end

  // program memory address; a user read takes one fetch slot
  always_comb begin
    nxt_pend_user = prog_rd_req;
    if (prog_rd_req) begin
      nxt_pmem_addr = prog_rd_addr[PROG_AW-1:0];
    end else begin
      nxt_pmem_addr = nxt_pc[PROG_AW-1:0];
    end
    nxt_prog_rd_valid = pend_user_ff;
    nxt_prog_rd_data  = pend_user_ff ? pmem_rdata : prog_rd_data_ff;
  end

  // data side pipeline, independent of the program port
  always_comb begin
    nxt_periph.sel   = dreq.req && (region == mmbd_pkg::MMBD_R_PERIPH);
    nxt_periph.we    = dreq.we;
    nxt_periph.addr  = eff_addr;
    nxt_periph.wdata = dreq.wdata;
    nxt_drvalid      = pend_read_ff;
    if (!pend_read_ff) begin
      nxt_drdata = drdata_ff;
    end else if (from_periph_ff) begin
      nxt_drdata = periph_hit ? periph_rdata : 8'h00;
    end else begin
      nxt_drdata = local_rd_ff;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pc_ff                <= `MMBD_RESET_VECTOR;
      pmem_addr_ff         <= '0;
      pend_user_ff         <= 1'b0;
      prog_rd_valid_ff     <= 1'b0;
      prog_rd_data_ff      <= 14'h0000;
      core_status_ff       <= `MMBD_RST_STATUS;
      indirect_pointer_ff  <= `MMBD_RST_PTR;
      pc_high_latch_ff     <= `MMBD_RST_PC_HIGH_LATCH;
      interrupt_control_ff <= `MMBD_RST_INT_CONTROL;
      periph_ff            <= '0;
      local_rd_ff          <= 8'h00;
      from_periph_ff       <= 1'b0;
      pend_read_ff         <= 1'b0;
      drdata_ff            <= 8'h00;
      drvalid_ff           <= 1'b0;
    end else begin
      pc_ff                <= nxt_pc;
      pmem_addr_ff         <= nxt_pmem_addr;
      pend_user_ff         <= nxt_pend_user;
      prog_rd_valid_ff     <= nxt_prog_rd_valid;
      prog_rd_data_ff      <= nxt_prog_rd_data;
      core_status_ff       <= nxt_status;
      indirect_pointer_ff  <= nxt_ptr;
      pc_high_latch_ff     <= nxt_program_counter_high_latch;
      interrupt_control_ff <= nxt_interrupt_control;
      periph_ff            <= nxt_periph;
      local_rd_ff          <= local_rd;
      from_periph_ff       <= (region == mmbd_pkg::MMBD_R_PERIPH);
      pend_read_ff         <= dreq.req && !dreq.we;
      drdata_ff            <= nxt_drdata;
      drvalid_ff           <= nxt_drvalid;
    end
  end

  // general RAM has no reset; contents are unknown after power-up
  always_ff @(posedge core_clk) begin
    if (wr && (region == mmbd_pkg::MMBD_R_RAM)) begin
      ram[ram_idx] <= dreq.wdata;
    end
  end

endmodule : mmbd_top
`default_nettype wire

// [sim/mmbd_top_asserts.sv]
// concurrent checks on the ports of the memory map block
`default_nettype none
module mmbd_top_asserts #(parameter int PROG_AW = 11) (
  // clock and program side
  input wire logic                   core_clk,
  input wire logic                   resetn,
  input wire logic                   pc_inc,
  input wire logic                   pc_jump,
  input wire logic [10:0]            pc_jump_target,
  input wire logic                   int_take,
  input wire logic [PROG_AW-1:0]     pmem_addr_ff,
  input wire logic [12:0]            pc_ff,
  input wire logic                   prog_rd_req,
  input wire logic [12:0]            prog_rd_addr,
  input wire logic                   prog_rd_valid_ff,
  // data side
  input wire mmbd_pkg::mmbd_dreq_t   dreq,
  input wire logic                   drvalid_ff,
  input wire logic [7:0]             pc_high_latch_ff,
  input wire mmbd_pkg::mmbd_periph_t periph_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // any data write may be a counter-low write, which outranks jumps
  wire logic       quiet = !(dreq.req && dreq.we) && !int_take;
  wire logic [1:0] page  = pc_high_latch_ff[4:3];
  wire logic [10:0] rd_lo = prog_rd_addr[10:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_read_answer: assert property (dreq.req && !dreq.we |-> ##2 drvalid_ff)
    else $error("read answer missing");
  chk_no_stray: assert property (drvalid_ff |-> $past(dreq.req && !dreq.we, 2))
    else $error("read answer without request");
  chk_int_vector: assert property (int_take |=> pc_ff == 13'h0004)
    else $error("interrupt vector wrong");
  chk_fetch_wrap: assert property (!$past(prog_rd_req) |-> pmem_addr_ff == pc_ff[10:0])
    else $error("fetch address not low counter bits");
  chk_pc_step: assert property (pc_inc && !pc_jump && quiet |=> pc_ff == $past(pc_ff) + 13'h1)
    else $error("counter step wrong");
  chk_jump_page: assert property (pc_jump && quiet |=> pc_ff == {$past(page), $past(pc_jump_target)})
    else $error("jump target wrong");
  chk_user_read: assert property (prog_rd_req |=> pmem_addr_ff == $past(rd_lo) ##1 prog_rd_valid_ff)
    else $error("user program read wrong");
  chk_periph_sel: assert property (dreq.req && !dreq.indirect && dreq.offset == 7'h05
    |=> periph_ff.sel && periph_ff.addr[6:0] == 7'h05)
    else $error("peripheral select wrong");
  cover property (drvalid_ff);
  cover property (prog_rd_valid_ff);
  cover property (int_take ##1 pc_inc);
endmodule : mmbd_top_asserts
bind mmbd_top mmbd_top_asserts #(.PROG_AW(PROG_AW)) i_chk (.core_clk, .resetn, .pc_inc,
  .pc_jump, .pc_jump_target, .int_take, .pmem_addr_ff, .pc_ff, .prog_rd_req, .prog_rd_addr,
  .prog_rd_valid_ff, .dreq, .drvalid_ff, .pc_high_latch_ff, .periph_ff);
`default_nettype wire

// [sim/mmbd_far_model.sv]
// far side stand-in: program word store and peripheral register space
`default_nettype none
module mmbd_far_model (
  input wire logic [10:0]            pmem_addr_ff,
  input wire mmbd_pkg::mmbd_periph_t periph_ff,
  output logic [13:0]                pmem_rdata,
  output logic                       periph_hit,
  output logic [7:0]                 periph_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // each word carries its address, so a wrong fetch address shows
  assign pmem_rdata   = {3'h5, pmem_addr_ff};
  // only offset 05h exists; a miss drives junk that must not pass
  assign periph_hit   = periph_ff.sel && periph_ff.addr[6:0] == 7'h05;
  assign periph_rdata = periph_hit ? 8'h77 : 8'hc3;
endmodule : mmbd_far_model
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the memory map block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, resetn = 1'b0, pc_inc = 1'b0, pc_jump = 1'b0, int_take = 1'b0;
  logic prog_rd_req = 1'b0, alu_flags_we = 1'b0;
  logic [10:0] pc_jump_target = 11'h000;
  logic [12:0] prog_rd_addr = 13'h0000;
  logic [2:0]  alu_flags = 3'h0;
  mmbd_pkg::mmbd_dreq_t   dreq = '0;
  mmbd_pkg::mmbd_periph_t periph_ff;
  logic [10:0] pmem_addr_ff;
  logic [13:0] pmem_rdata, prog_rd_data_ff;
  logic [12:0] pc_ff;
  logic        prog_rd_valid_ff, drvalid_ff, periph_hit;
  logic [7:0]  drdata_ff, core_status_ff, indirect_pointer_ff, pc_high_latch_ff;
  logic [7:0]  interrupt_control_ff, periph_rdata;
  int          fails = 0, check_count = 0;
  always #2 core_clk = ~core_clk;
  mmbd_top i_dut (.core_clk, .resetn, .pc_inc, .pc_jump, .pc_jump_target, .int_take,
    .pmem_addr_ff, .pmem_rdata, .pc_ff, .prog_rd_req, .prog_rd_addr, .prog_rd_data_ff,
    .prog_rd_valid_ff, .dreq, .alu_flags_we, .alu_flags, .drdata_ff, .drvalid_ff,
    .core_status_ff, .indirect_pointer_ff, .pc_high_latch_ff, .interrupt_control_ff,
    .periph_ff, .periph_hit, .periph_rdata);
  mmbd_far_model i_far (.pmem_addr_ff, .periph_ff, .pmem_rdata, .periph_hit, .periph_rdata);
  task automatic cmp_data(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_data
  task automatic cmp_prog(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_prog
  // idle cycle after each write keeps two requests from meeting in one step
  task automatic dwr(input logic [6:0] o, input logic [7:0] d);
    dreq = '{1'b1, 1'b1, 1'b0, o, d};
    @(negedge core_clk);
    dreq = '0;
    @(negedge core_clk);
  endtask : dwr
  task automatic drd(input logic i, input logic [6:0] o, input logic [7:0] e);
    dreq = '{1'b1, 1'b0, i, o, 8'h00};
    @(negedge core_clk);
    dreq = '0;
    // the answer stands for one cycle only, one rising edge after the taking edge
    @(negedge core_clk);
    cmp_data("drvalid", 8'h01, {7'h00, drvalid_ff});
    cmp_data("drdata", e, drdata_ff);
  endtask : drd
  task automatic bank(input logic [1:0] b);
    dwr(7'h03, {1'b0, b, 5'h00});
  endtask : bank
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    #5000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    cmp_data("status", 8'h18, core_status_ff);
    cmp_prog("pc", 16'h0000, {3'h0, pc_ff});
    for (int b = 0; b < 4; b++) begin
      bank(b[1:0]);
      drd(1'b0, 7'h03, {1'b0, b[1:0], 5'h18});
      drd(1'b0, 7'h04, (b == 0) ? 8'h00 : 8'h3f + b[7:0]);
      dwr(7'h04, 8'h40 + b[7:0]);
    end
    alu_flags = 3'h5;
    alu_flags_we = 1'b1;
    @(negedge core_clk);
    alu_flags_we = 1'b0;
    cmp_data("status", 8'h7d, core_status_ff);
    dwr(7'h0b, 8'h5a);
    cmp_data("interrupt_control", 8'h5a, interrupt_control_ff);
    bank(2'h1);
    drd(1'b0, 7'h0b, 8'h5a);
    bank(2'h0);
    dwr(7'h20, 8'ha5);
    dwr(7'h7f, 8'h5e);
    drd(1'b0, 7'h7f, 8'h5e);
    bank(2'h2);
    drd(1'b0, 7'h20, 8'ha5);
    bank(2'h1);
    dwr(7'h40, 8'h3c);
    dwr(7'h20, 8'h66);
    bank(2'h3);
    drd(1'b0, 7'h20, 8'h66);
    bank(2'h0);
    drd(1'b0, 7'h40, 8'h3c);
    dwr(7'h04, 8'h21);
    cmp_data("pointer", 8'h21, indirect_pointer_ff);
    dwr(7'h00, 8'h99);
    drd(1'b0, 7'h21, 8'h99);
    drd(1'b1, 7'h55, 8'h99);
    drd(1'b0, 7'h05, 8'h77);
    drd(1'b0, 7'h08, 8'h00);
    dwr(7'h0a, 8'hf8);
    cmp_data("program_counter_high_latch", 8'h18, pc_high_latch_ff);
    pc_jump_target = 11'h7ff;
    pc_jump = 1'b1;
    @(negedge core_clk);
    pc_jump = 1'b0;
    cmp_prog("pc", 16'h1fff, {3'h0, pc_ff});
    cmp_prog("word", 16'h2fff, {2'h0, pmem_rdata});
    pc_inc = 1'b1;
    drd(1'b0, 7'h20, 8'ha5);
    pc_inc = 1'b0;
    cmp_prog("pc", 16'h0001, {3'h0, pc_ff});
    cmp_prog("word", 16'h2801, {2'h0, pmem_rdata});
    int_take = 1'b1;
    @(negedge core_clk);
    int_take = 1'b0;
    cmp_prog("pc", 16'h0004, {3'h0, pc_ff});
    dwr(7'h02, 8'h10);
    cmp_prog("pc", 16'h1810, {3'h0, pc_ff});
    drd(1'b0, 7'h02, 8'h10);
    prog_rd_addr = 13'h1805;
    prog_rd_req = 1'b1;
    @(negedge core_clk);
    prog_rd_req = 1'b0;
    cmp_prog("paddr", 16'h0005, {5'h00, pmem_addr_ff});
    @(negedge core_clk);
    cmp_prog("pvalid", 16'h0001, {15'h0000, prog_rd_valid_ff});
    cmp_prog("pdata", 16'h2805, {2'h0, prog_rd_data_ff});
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
